/* File: common/alu_pkg.sv */
/*
  package of the add-with-carry / logic-op execute datapath: register map,
  field positions, reset values, quarter-cycle phase codes, opcode patterns,
  flag positions and the carrier types shared by the datapath.
  assumes a single 40 MHz clock domain and an axi4-lite register bus.
*/
// Overview of operation
// - opcode 001000da adds accumulator, carry, file byte
// - sum destination bit: 0 accumulator, 1 file
// - access bit 0 access bank, 1 bank pointer
// - extended set, a=0, f<=95: indexed offset mode
// - opcode 00001011: literal and, only n z
// - opcode 000101da ands accumulator with file byte
// - and destination bit: 0 accumulator, 1 file
// - literal and: decode, read, process, write quarters
package alu_pkg;
  ////////////////////////////////////////////////////////////////////////////
  // register map (byte addresses) and widths
  localparam int          ADDR_W       = 8;
  localparam logic [7:0]  OFS_CTRL     = 8'h00;
  localparam logic [7:0]  OFS_OPCODE   = 8'h04;
  localparam logic [7:0]  OFS_ACCUM    = 8'h08;
  localparam logic [7:0]  OFS_STATUS   = 8'h0C;
  localparam logic [7:0]  OFS_BANK     = 8'h10;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;
  // flag positions inside the status register
  localparam int          FLG_C        = 0;
  localparam int          FLG_NIBBLE   = 1;
  localparam int          FLG_Z        = 2;
  localparam int          FLG_WRAP     = 3;
  localparam int          FLG_N        = 4;
  localparam int          STAT_BUSY    = 8;
  localparam int          CTRL_EXT     = 0;
  // reset values
  localparam logic [7:0]  RST_ACCUM    = 8'h00;
  localparam logic [4:0]  RST_FLAGS    = 5'h00;
  localparam logic [3:0]  RST_BANK     = 4'h0;
  // opcode fields and patterns
  localparam logic [5:0]  OP_SUM_C     = 6'h08;   // 0010 00da
  localparam logic [5:0]  OP_FMASK     = 6'h05;   // 0001 01da
  localparam logic [7:0]  OP_LMASK     = 8'h0B;   // 0000 1011
  localparam int          BIT_DEST     = 9;
  localparam int          BIT_ACC      = 8;
  // addressing
  localparam logic [7:0]  IDX_LIMIT    = 8'h5F;   // 95
  localparam logic [7:0]  ACC_SPLIT    = 8'h60;
  localparam logic [3:0]  ACC_HI_BANK  = 4'hF;
  localparam logic [3:0]  ACC_LO_BANK  = 4'h0;

  // quarter-cycle phases, one-hot
  typedef enum logic [4:0] {
    PH_IDLE = 5'b00001,
    PH_Q1   = 5'b00010,
    PH_Q2   = 5'b00100,
    PH_Q3   = 5'b01000,
    PH_Q4   = 5'b10000
  } phase_t;

  // data memory request carried to the partner
  typedef struct packed {
    logic [11:0] addr;
    logic [7:0]  wdata;
    logic        re;
    logic        we;
    logic        idx;
  } mem_req_t;

  // complete state of the datapath
  typedef struct packed {
    phase_t      phase;
    logic [15:0] opcode;
    logic [7:0]  acc;
    logic [4:0]  flags;
    logic [3:0]  bank;
    logic        ext_en;
    logic [7:0]  result;
    logic [4:0]  new_flags;
    mem_req_t    mem;
    logic        aw_got;
    logic [7:0]  awaddr;
    logic        w_got;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
  } state_t;
endpackage

/* File: logic/alu_exec.sv */
/*
  execute datapath for the accumulator/file sum with carry, the literal mask
  and the file mask instructions, with its axi4-lite register slave.
  assumes the data memory answers a read one clock after mem.re and writes
  on the clock edge that ends a cycle with mem.we high.
*/
`timescale 1ns/1ps
module alu_exec (
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic [7:0]          s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [7:0]          s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  output alu_pkg::mem_req_t        mem_req,
  input  wire logic [7:0]          mem_rdata
);

  alu_pkg::state_t st_reg;
  alu_pkg::state_t st_next;

  logic [31:0] wmask;
  logic [7:0]  operand;
  logic [8:0]  sum9;
  logic [4:0]  nib5;
  logic [7:0]  mask_res;
  logic        is_sum;
  logic        is_fmask;
  logic        is_lmask;
  logic        use_file;
  logic        wr_go;
  logic        wr_ok;
  logic [7:0]  fadr;

  ////////////////////////////////////////////////////////////////////////////
  // decode of the held opcode
  assign is_sum   = st_reg.opcode[15:10] == alu_pkg::OP_SUM_C;
  assign is_fmask = st_reg.opcode[15:10] == alu_pkg::OP_FMASK;
  assign is_lmask = st_reg.opcode[15:8] == alu_pkg::OP_LMASK;
  assign use_file = is_sum | is_fmask;
  assign fadr     = st_reg.opcode[7:0];

  // operand is the literal or the byte returned by data memory in q3
  assign operand  = is_lmask ? st_reg.opcode[7:0] : mem_rdata;
  assign sum9     = {1'b0, st_reg.acc} + {1'b0, operand}
                  + {8'h00, st_reg.flags[alu_pkg::FLG_C]};
  assign nib5     = {1'b0, st_reg.acc[3:0]} + {1'b0, operand[3:0]}
                  + {4'h0, st_reg.flags[alu_pkg::FLG_C]};
  assign mask_res = st_reg.acc & operand;

  // byte lanes of the pending write
  assign wmask = {{8{st_reg.wstrb[3]}}, {8{st_reg.wstrb[2]}},
                  {8{st_reg.wstrb[1]}}, {8{st_reg.wstrb[0]}}};

  // handshake outputs follow the capture state
  assign s_axi_awready = !st_reg.aw_got && !st_reg.bvalid;
  assign s_axi_wready  = !st_reg.w_got && !st_reg.bvalid;
  assign s_axi_arready = !st_reg.rvalid;
  assign wr_go         = st_reg.aw_got && st_reg.w_got && !st_reg.bvalid;

  // data outputs straight from the state register
  assign s_axi_bvalid = st_reg.bvalid;
  assign s_axi_bresp  = st_reg.bresp;
  assign s_axi_rvalid = st_reg.rvalid;
  assign s_axi_rresp  = st_reg.rresp;
  assign s_axi_rdata  = st_reg.rdata;
  assign mem_req      = st_reg.mem;

  ////////////////////////////////////////////////////////////////////////////
  // next state: bus slave, quarter-cycle sequencer and alu
  always_comb begin
    st_next        = st_reg;
    wr_ok          = 1'b1;
    st_next.mem.re = 1'b0;
    st_next.mem.we = 1'b0;

    // address and data channels are captured independently
    if (s_axi_awvalid && s_axi_awready) begin
      st_next.aw_got = 1'b1;
      st_next.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      st_next.w_got = 1'b1;
      st_next.wdata = s_axi_wdata;
      st_next.wstrb = s_axi_wstrb;
    end
    if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
    end

    // quarter-cycle sequencer, one instruction cycle per opcode
    unique case (st_reg.phase)
      alu_pkg::PH_IDLE: begin
      end
      alu_pkg::PH_Q1: begin
        // decode: form the file address for the q2 read
        st_next.phase        = alu_pkg::PH_Q2;
        st_next.mem.re       = use_file;
        st_next.mem.idx      = 1'b0;
        st_next.mem.addr     = {st_reg.bank, fadr};
        if (!st_reg.opcode[alu_pkg::BIT_ACC]) begin
          if (st_reg.ext_en && fadr <= alu_pkg::IDX_LIMIT) begin
            st_next.mem.idx  = 1'b1;
            st_next.mem.addr = {4'h0, fadr};
          end else if (fadr < alu_pkg::ACC_SPLIT) begin
            st_next.mem.addr = {alu_pkg::ACC_LO_BANK, fadr};
          end else begin
            st_next.mem.addr = {alu_pkg::ACC_HI_BANK, fadr};
          end
        end
      end
      alu_pkg::PH_Q2: begin
        // memory read in flight, literal already held
        st_next.phase = alu_pkg::PH_Q3;
      end
      alu_pkg::PH_Q3: begin
        // process data and stage the write of q4
        st_next.phase     = alu_pkg::PH_Q4;
        st_next.new_flags = st_reg.flags;
        if (is_sum) begin
          st_next.result = sum9[7:0];
          st_next.new_flags[alu_pkg::FLG_C]  = sum9[8];
          st_next.new_flags[alu_pkg::FLG_NIBBLE] = nib5[4];
          st_next.new_flags[alu_pkg::FLG_WRAP]   =
            (st_reg.acc[7] == operand[7]) && (sum9[7] != st_reg.acc[7]);
          st_next.new_flags[alu_pkg::FLG_N]  = sum9[7];
          st_next.new_flags[alu_pkg::FLG_Z]  = sum9[7:0] == 8'h00;
        end else begin
          st_next.result = mask_res;
          st_next.new_flags[alu_pkg::FLG_N]  = mask_res[7];
          st_next.new_flags[alu_pkg::FLG_Z]  = mask_res == 8'h00;
        end
        if (use_file && st_reg.opcode[alu_pkg::BIT_DEST]) begin
          st_next.mem.we    = 1'b1;
          st_next.mem.wdata = is_sum ? sum9[7:0] : mask_res;
        end
      end
      alu_pkg::PH_Q4: begin
        // write back: accumulator unless the file took the result
        st_next.phase = alu_pkg::PH_IDLE;
        st_next.flags = st_reg.new_flags;
        if (is_lmask || !st_reg.opcode[alu_pkg::BIT_DEST]) begin
          st_next.acc = st_reg.result;
        end
      end
      default: begin
        st_next.phase = alu_pkg::PH_IDLE;
      end
    endcase

    // register write once both channels are held
    if (wr_go) begin
      st_next.aw_got = 1'b0;
      st_next.w_got  = 1'b0;
      st_next.bvalid = 1'b1;
      unique case (st_reg.awaddr)
        alu_pkg::OFS_CTRL: begin
          if (st_reg.wstrb[0]) begin
            st_next.ext_en = st_reg.wdata[alu_pkg::CTRL_EXT];
          end
        end
        alu_pkg::OFS_OPCODE: begin
          // a new opcode launches only from idle and with both low lanes
          if (st_reg.phase == alu_pkg::PH_IDLE && st_reg.wstrb[1:0] == 2'b11) begin
            st_next.opcode = st_reg.wdata[15:0];
            st_next.phase  = alu_pkg::PH_Q1;
          end else begin
            wr_ok = 1'b0;
          end
        end
        alu_pkg::OFS_ACCUM: begin
          if (st_reg.phase == alu_pkg::PH_IDLE) begin
            st_next.acc = (st_reg.acc & ~wmask[7:0]) | (st_reg.wdata[7:0] & wmask[7:0]);
          end else begin
            wr_ok = 1'b0;
          end
        end
        alu_pkg::OFS_STATUS: begin
          if (st_reg.phase == alu_pkg::PH_IDLE) begin
            st_next.flags = (st_reg.flags & ~wmask[4:0]) | (st_reg.wdata[4:0] & wmask[4:0]);
          end else begin
            wr_ok = 1'b0;
          end
        end
        alu_pkg::OFS_BANK: begin
          st_next.bank = (st_reg.bank & ~wmask[3:0]) | (st_reg.wdata[3:0] & wmask[3:0]);
        end
        default: begin
          wr_ok = 1'b0;
        end
      endcase
      st_next.bresp = wr_ok ? alu_pkg::RESP_OKAY : alu_pkg::RESP_SLVERR;
    end

    // read channel: one answer held until taken
    if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      st_next.rvalid = 1'b1;
      st_next.rresp  = alu_pkg::RESP_OKAY;
      st_next.rdata  = 32'h0000_0000;
      unique case (s_axi_araddr)
        alu_pkg::OFS_CTRL:   st_next.rdata[alu_pkg::CTRL_EXT] = st_reg.ext_en;
        alu_pkg::OFS_OPCODE: st_next.rdata[15:0] = st_reg.opcode;
        alu_pkg::OFS_ACCUM:  st_next.rdata[7:0]  = st_reg.acc;
        alu_pkg::OFS_STATUS: begin
          st_next.rdata[4:0]                = st_reg.flags;
          st_next.rdata[alu_pkg::STAT_BUSY] = st_reg.phase != alu_pkg::PH_IDLE;
        end
        alu_pkg::OFS_BANK:   st_next.rdata[3:0]  = st_reg.bank;
        default:             st_next.rresp = alu_pkg::RESP_SLVERR;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register, synchronous active-low reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg       <= '0;
      st_reg.phase <= alu_pkg::PH_IDLE;
      st_reg.acc   <= alu_pkg::RST_ACCUM;
      st_reg.flags <= alu_pkg::RST_FLAGS;
      st_reg.bank  <= alu_pkg::RST_BANK;
    end else begin
      st_reg <= st_next;
    end
  end

endmodule

/* File: verification/alu_exec_sva.sv */
/*
  checker for the execute datapath: memory strobe order and bus handshakes.
  assumes one clock, synchronous active-low reset; bound by the statement below.
*/
`timescale 1ns/1ps
module alu_exec_sva (
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic [1:0]        s_axi_bresp,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  input wire alu_pkg::mem_req_t mem_req
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////////////////
  // memory strobes: read in one phase, write two phases later, same place
  a_read_single: assert property (mem_req.re |=> !mem_req.re)
    else $error("read strobe longer than one cycle");
  a_write_after_read: assert property (mem_req.we |-> $past(mem_req.re, 2))
    else $error("write strobe without read two cycles before");
  a_write_same_addr: assert property (mem_req.we |-> mem_req.addr == $past(mem_req.addr, 2))
    else $error("write address differs from read address");
  a_indexed_window: assert property (mem_req.re && mem_req.idx |-> mem_req.addr <= 12'h05F)
    else $error("indexed request outside low window");
  ////////////////////////////////////////////////////////////////////////////
  // bus answers and holding
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write answer late");
  a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp)) else $error("write answer dropped");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata)) else $error("read data dropped");
  // main scenarios seen
  c_file_read: cover property (mem_req.re);
  c_file_write: cover property (mem_req.we);
  c_indexed: cover property (mem_req.idx && mem_req.re);
  c_refused: cover property (s_axi_bvalid && s_axi_bresp == alu_pkg::RESP_SLVERR);
endmodule
bind alu_exec alu_exec_sva i_sva (.*);

/* File: verification/data_ram_model.sv */
/*
  behavioural data memory facing the datapath.
  assumes requests come as mem_req_t, read data wanted the cycle after re.
*/
`timescale 1ns/1ps
module data_ram_model (
  input wire logic              aclk,
  input wire alu_pkg::mem_req_t req,
  output logic [7:0]            rdata
);
  logic [7:0] mem [0:4095];
  initial rdata = 8'h00;
  ////////////////////////////////////////////////////////////////////////////
  // answer a read next cycle; otherwise show a changing pattern
  always @(posedge aclk) begin
    rdata <= req.re ? mem[req.addr] : ~rdata;
    if (req.we) mem[req.addr] <= req.wdata;
  end
endmodule

/* File: verification/test_add_carry_and_logic_ops.sv */
/*
  testbench: table of instructions, then refusal, unmapped and reset cases.
  assumes the datapath and the memory model above, one 40 MHz clock.
*/
`timescale 1ns/1ps
module test_add_carry_and_logic_ops;
  typedef struct packed {
    logic ext; logic [4:0] fl; logic [7:0] acc, mb; logic [15:0] op;
    logic [11:0] ea; logic ei; logic [7:0] eacc; logic [4:0] efl; logic [7:0] emb;
  } row_t;
  logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, seen_re, seen_idx;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, mem_rdata;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [11:0] seen_addr;
  alu_pkg::mem_req_t mem_req;
  int num_errors = 0, total_checks = 0;
  row_t rows [7] = '{
    '{1'b0, 5'h01, 8'h02, 8'h4D, 16'h2120, 12'h220, 1'b0, 8'h50, 5'h02, 8'h4D},
    '{1'b0, 5'h00, 8'h7F, 8'h01, 16'h2270, 12'hF70, 1'b0, 8'h7F, 5'h1A, 8'h80},
    '{1'b0, 5'h01, 8'hFF, 8'h00, 16'h2010, 12'h010, 1'b0, 8'h00, 5'h07, 8'h00},
    '{1'b0, 5'h1D, 8'hA3, 8'h00, 16'h0B5F, 12'h000, 1'b0, 8'h03, 5'h09, 8'h00},
    '{1'b0, 5'h1F, 8'h17, 8'hC2, 16'h1733, 12'h233, 1'b0, 8'h17, 5'h0B, 8'h02},
    '{1'b1, 5'h00, 8'hF0, 8'h0F, 16'h1460, 12'hF60, 1'b0, 8'h00, 5'h04, 8'h0F},
    '{1'b1, 5'h00, 8'h01, 8'h01, 16'h205F, 12'h05F, 1'b1, 8'h02, 5'h00, 8'h01}};
  alu_exec i_dut (.*);
  data_ram_model i_mem (.aclk(aclk), .req(mem_req), .rdata(mem_rdata));
  always #12.5 aclk = ~aclk;
  // note where the datapath reads memory
  always @(posedge aclk) if (mem_req.re) begin
    seen_re <= 1'b1;
    seen_addr <= mem_req.addr;
    seen_idx <= mem_req.idx;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] g, e, input string m);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value at %0t: %s got %h want %h", $time, m, g, e);
    end
  endtask
  // bus write: hold each channel until taken, wait for the answer
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    s_axi_awaddr <= a; s_axi_wdata <= v; s_axi_bready <= 1;
    s_axi_awvalid <= 1; s_axi_wvalid <= 1;
    forever begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
      if (s_axi_bvalid) break;
    end
    // bready stays up so back-to-back writes never toggle it in one step
    rs = s_axi_bresp;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
    forever begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 0;
      if (s_axi_rvalid) break;
    end
    v = s_axi_rdata; rs = s_axi_rresp;
  endtask
  task automatic run(input logic [15:0] op, output logic [1:0] rs);
    wr(alu_pkg::OFS_OPCODE, {16'h0000, op}, rs);
    do rd(alu_pkg::OFS_STATUS, d, r); while (d[alu_pkg::STAT_BUSY] !== 1'b0);
  endtask
  task automatic tally_and_finish;
    if (num_errors == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1;
    foreach (rows[i]) begin
      wr(alu_pkg::OFS_CTRL, {31'h0, rows[i].ext}, r);
      wr(alu_pkg::OFS_BANK, 32'h0000_0002, r);
      wr(alu_pkg::OFS_ACCUM, {24'h0, rows[i].acc}, r);
      wr(alu_pkg::OFS_STATUS, {27'h0, rows[i].fl}, r);
      i_mem.mem[rows[i].ea] = rows[i].mb;
      seen_re = 0;
      run(rows[i].op, r);
      rd(alu_pkg::OFS_ACCUM, d, r); chk(d, {24'h0, rows[i].eacc}, "accum");
      rd(alu_pkg::OFS_STATUS, d, r); chk(d, {27'h0, rows[i].efl}, "flags");
      if (rows[i].op[15:8] == 8'h0B) chk(seen_re, 1'b0, "literal read");
      else begin
        chk(seen_addr, rows[i].ea, "operand place");
        chk(seen_idx, rows[i].ei, "indexed mode");
        chk(i_mem.mem[rows[i].ea], rows[i].emb, "memory byte");
      end
    end
    // second opcode while busy is refused and leaves the first result
    wr(alu_pkg::OFS_ACCUM, 32'h0000_00FF, r);
    wr(alu_pkg::OFS_OPCODE, 32'h0000_0B5F, r);
    wr(alu_pkg::OFS_OPCODE, 32'h0000_0B00, r); chk(r, alu_pkg::RESP_SLVERR, "busy write");
    run(16'h0B0F, r);
    rd(alu_pkg::OFS_ACCUM, d, r); chk(d, 32'h0000_000F, "chained and");
    rd(8'h20, d, r); chk(r, alu_pkg::RESP_SLVERR, "unmapped read");
    chk(d, 32'h0000_0000, "unmapped data");
    wr(8'h24, 32'h0000_0001, r); chk(r, alu_pkg::RESP_SLVERR, "unmapped write");
    // opcode write without both low lanes is refused and runs nothing
    s_axi_wstrb <= 4'h1;
    wr(alu_pkg::OFS_OPCODE, 32'h0000_0B00, r);
    chk(r, alu_pkg::RESP_SLVERR, "opcode lanes");
    s_axi_wstrb <= 4'hF;
    rd(alu_pkg::OFS_ACCUM, d, r); chk(d, 32'h0000_000F, "refused opcode");
    // a stalled master sees the write answer, then the read answer, held
    s_axi_bready <= 0;
    s_axi_awaddr <= alu_pkg::OFS_BANK;
    s_axi_wdata <= 32'h0000_0005;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    do @(posedge aclk); while (!(s_axi_awready && s_axi_wready));
    s_axi_awvalid <= 0;
    s_axi_wvalid <= 0;
    repeat (3) @(posedge aclk);
    s_axi_bready <= 1;
    do @(posedge aclk); while (!s_axi_bvalid);
    chk(s_axi_bresp, alu_pkg::RESP_OKAY, "held write");
    s_axi_rready <= 0;
    s_axi_araddr <= alu_pkg::OFS_BANK;
    s_axi_arvalid <= 1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 0;
    repeat (3) @(posedge aclk);
    s_axi_rready <= 1;
    do @(posedge aclk); while (!s_axi_rvalid);
    chk(s_axi_rdata, 32'h0000_0005, "held read");
    // give every flag a set value so the reset check can see it cleared
    wr(alu_pkg::OFS_STATUS, 32'h0000_001F, r);
    // reset mid-run returns registers to their reset values
    aresetn <= 0;
    repeat (3) @(posedge aclk);
    aresetn <= 1;
    rd(alu_pkg::OFS_ACCUM, d, r); chk(d, {24'h0, alu_pkg::RST_ACCUM}, "reset accum");
    rd(alu_pkg::OFS_STATUS, d, r); chk(d, {27'h0, alu_pkg::RST_FLAGS}, "reset flags");
    rd(alu_pkg::OFS_BANK, d, r); chk(d, {28'h0, alu_pkg::RST_BANK}, "reset bank");
    rd(alu_pkg::OFS_CTRL, d, r); chk(d, 32'h0000_0000, "reset control");
    tally_and_finish;
  end
  // hang guard, far beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge aclk);
    num_errors++;
    tally_and_finish;
  end
endmodule
